/* File: hot_swap_pkg.sv */
// Shared constants for the hot-swap fault sequencer and its integrator
package hot_swap_pkg;

    // ====================
    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 50;          // 20 MHz system clock
    localparam int unsigned TICK_SHORT_NS = 32000;       // Integrator tick, short-limit variant
    localparam int unsigned TICK_LONG_NS = 128000;       // Integrator tick, long-limit variant
    localparam int unsigned LIMIT_SHORT_NS = 500000;     // Longest current limit, short variant
    localparam int unsigned LIMIT_LONG_NS = 2000000;     // Longest current limit, long variant
    localparam int unsigned DUTY_RATIO = 128;            // Down count is this much slower
    localparam int unsigned RESTART_HOLD_US = 150000;    // Restart hold time, plain default
    localparam int unsigned CLK_PER_US = 1000 / CLK_PERIOD_NS;

    localparam int unsigned TICK_W = 12;
    localparam logic [TICK_W-1:0] TICK_SHORT_CYC = TICK_W'(TICK_SHORT_NS / CLK_PERIOD_NS);
    localparam logic [TICK_W-1:0] TICK_LONG_CYC = TICK_W'(TICK_LONG_NS / CLK_PERIOD_NS);
    // Limit reached after this many ticks, rounded up to whole ticks
    localparam int unsigned LIMIT_TICKS_SHORT = (LIMIT_SHORT_NS + TICK_SHORT_NS - 1) / TICK_SHORT_NS;
    localparam int unsigned LIMIT_TICKS_LONG = (LIMIT_LONG_NS + TICK_LONG_NS - 1) / TICK_LONG_NS;

    localparam int unsigned INTEG_W = 12;
    localparam logic [INTEG_W-1:0] INTEG_UP = INTEG_W'(DUTY_RATIO);
    localparam logic [INTEG_W-1:0] INTEG_LIMIT_SHORT = INTEG_W'(LIMIT_TICKS_SHORT * DUTY_RATIO);
    localparam logic [INTEG_W-1:0] INTEG_LIMIT_LONG = INTEG_W'(LIMIT_TICKS_LONG * DUTY_RATIO);

    localparam int unsigned HOLD_W = 32;
    localparam logic [HOLD_W-1:0] RESTART_HOLD_CYC = HOLD_W'(RESTART_HOLD_US * CLK_PER_US);

    // ====================
    // Register map (byte addresses on the AXI4-Lite bus)
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;    // Bit 0: software hold-off
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;  // Live state, read only
    localparam logic [ADDR_W-1:0] FAULT_OFS = 8'h08;   // Sticky causes, write 1 to clear
    localparam logic [ADDR_W-1:0] INTEG_OFS = 8'h0c;   // Integrator level, read only
    localparam logic [ADDR_W-1:0] CONFIG_OFS = 8'h10;  // Variant bits, read only
    localparam logic CTRL_RESET = 1'b0;
    localparam int unsigned FAULT_W = 5;
    localparam logic [FAULT_W-1:0] FAULT_RESET = 5'h00;
    localparam int unsigned FLT_OC = 0;
    localparam int unsigned FLT_HOT = 1;
    localparam int unsigned FLT_UV = 2;
    localparam int unsigned FLT_OV = 3;
    localparam int unsigned FLT_LOCK = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ====================
    // Sequencer states
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,    // Waiting for start conditions
        ST_ON = 2'b01,     // Pass switch driven
        ST_HOLD = 2'b10,   // Restart hold time running
        ST_LATCH = 2'b11   // Latched off, waiting for a low supply_above_min_in
    } seq_state_t;

endpackage : hot_swap_pkg

/* File: fault_integrator.sv */
// Up/down overcurrent fault integrator clocked by a fixed tick
`timescale 1ns/1ps

module fault_integrator #(
    parameter bit LONG_LIMIT = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic over_limit_i,
    input wire logic clear_i,
    output logic fault_o,
    output logic [hot_swap_pkg::INTEG_W-1:0] level_o
);
    import hot_swap_pkg::*;

    // ====================
    // Tick length and trip level per variant
    localparam logic [TICK_W-1:0] TICK_LAST = (LONG_LIMIT ? TICK_LONG_CYC : TICK_SHORT_CYC) - 1'b1;
    localparam logic [INTEG_W-1:0] TRIP = LONG_LIMIT ? INTEG_LIMIT_LONG : INTEG_LIMIT_SHORT;

    logic [TICK_W-1:0] tick_ff, nxt_tick;      // Cycle within tick
    logic seen_ff, nxt_seen;                   // Overcurrent seen this tick
    logic [INTEG_W-1:0] level_ff, nxt_level;   // Accumulated level
    logic fault_ff, nxt_fault;                 // Trip flag

    // ====================
    // Next state: up by the ratio per busy tick, down by one per quiet tick
    always_comb begin
        nxt_tick = tick_ff + 1'b1;
        nxt_seen = seen_ff | over_limit_i;             // R21
        nxt_level = level_ff;
        nxt_fault = fault_ff;
        if (clear_i) begin
            // Restart from a clean slate after the sequencer acts
            nxt_tick = '0;
            nxt_seen = 1'b0;
            nxt_level = '0;
            nxt_fault = 1'b0;
        end else if (tick_ff == TICK_LAST) begin
            nxt_tick = '0;
            nxt_seen = 1'b0;
            if (seen_ff | over_limit_i) begin
                // A short burst anywhere in the tick counts as the whole tick
                if (level_ff + INTEG_UP >= TRIP) begin  // R5
                    nxt_level = TRIP;
                    nxt_fault = 1'b1;                   // R6 R8
                end else begin
                    nxt_level = level_ff + INTEG_UP;    // R3
                end
            end else if (level_ff != '0) begin
                nxt_level = level_ff - 1'b1;            // R7
            end
        end
    end

    // ====================
    // Registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_ff <= '0;
            seen_ff <= 1'b0;
            level_ff <= '0;
            fault_ff <= 1'b0;
        end else begin
            tick_ff <= nxt_tick;   // R4
            seen_ff <= nxt_seen;
            level_ff <= nxt_level;
            fault_ff <= nxt_fault;
        end
    end

    assign fault_o = fault_ff;
    assign level_o = level_ff;

endmodule : fault_integrator

/* File: hot_swap_fault_sequencer.sv */
// Hot-swap fault sequencer: gate enable, power-good and AXI4-Lite registers
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps

// Operation
// [R1] Start only with supply window, lockout, low current
// [R2] Any fault drops the gate drive at once
// [R3] Overcurrent raises integrator once per tick
// [R4] Tick is 32us short or 128us long
// [R5] Sub-tick overcurrent counts a full tick
// [R6] Trip at 500us short or 2ms long
// [R7] Quiet ticks count down 128 times slower
// [R8] Excess overcurrent duty ratio also trips
// [R9] Overtemperature drops the gate drive
// [R10] Autoretry thermal: hold off restart hold time
// [R11] Autoretry thermal: restart only once cooled 20C
// [R12] Latched thermal: off until undervoltage toggle
// [R13] Latched clear still waits restart hold time
// [R14] Power-good needs drain low and gate high
// [R15] Power-good drops on drain high or undervoltage
// [R16] Power-good polarity fixed per variant
// [R17] Overvoltage never toggles asserted power-good
// [R18] Autoretry overcurrent restarts after hold time
// [R19] Latched overcurrent needs toggle plus hold time
// [R20] Hold time and variant are fixed parameters
// [R21] Overcurrent synchronised, sampled once per tick
module hot_swap_fault_sequencer #(
    parameter bit AUTORETRY = 1'b1,
    parameter bit LONG_LIMIT = 1'b0,
    parameter bit PG_ACTIVE_HIGH = 1'b0,
    parameter logic [hot_swap_pkg::HOLD_W-1:0] RESTART_HOLD_CYC = hot_swap_pkg::RESTART_HOLD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Comparator results, asynchronous to clk_i
    input wire logic supply_above_min_in_i,
    input wire logic supply_high_flag_in_i,
    input wire logic lockout_release_level_i,
    input wire logic limit_trip_level_i,
    input wire logic load_side_low_threshold_i,
    input wire logic drive_margin_level_i,
    input wire logic overheat_limit_i,
    input wire logic overheat_cooled_i,
    // Drive outputs
    output logic gate_enable_o,
    output logic power_good_out_o,
    // AXI4-Lite slave
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [hot_swap_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [hot_swap_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    import hot_swap_pkg::*;

    // ====================
    // Input synchronisers
    localparam int unsigned N_IN = 8;
    logic [N_IN-1:0] raw_in;                // Pins gathered for the loop
    logic [N_IN-1:0] meta_ff;               // First stage, read only by stage two
    logic [N_IN-1:0] sync_ff;               // Safe copies for the logic
    assign raw_in = {overheat_cooled_i, overheat_limit_i, drive_margin_level_i,
                     load_side_low_threshold_i, limit_trip_level_i,
                     lockout_release_level_i, supply_high_flag_in_i, supply_above_min_in_i};

    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_sync
            // Two flops per comparator; they change at analog pace
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                end else begin
                    meta_ff[gi] <= raw_in[gi];
                    sync_ff[gi] <= meta_ff[gi];    // R21
                end
            end
        end
    endgenerate

    logic uv_ok, ov_high, lock_ok, oc_now, drain_low, gate_high, hot, cooled;
    assign {cooled, hot, gate_high, drain_low, oc_now, lock_ok, ov_high, uv_ok} = sync_ff;

    // ====================
    // Overcurrent integrator
    logic oc_fault;                          // Integrator tripped
    logic [INTEG_W-1:0] integ_level;         // For the integrator level register
    logic integ_clear;                       // Reset while switch is off
    seq_state_t state_ff, nxt_state;

    // Only integrate while driving; a stale level must not trip a restart
    assign integ_clear = (state_ff != ST_ON);

    fault_integrator #(
        .LONG_LIMIT(LONG_LIMIT)
    ) u_integ (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .over_limit_i(oc_now),
        .clear_i(integ_clear),
        .fault_o(oc_fault),
        .level_o(integ_level)
    );

    // ====================
    // Sequencer
    logic [HOLD_W-1:0] hold_ff, nxt_hold;  // Restart hold down-counter
    logic thermal_ff, nxt_thermal;         // Hold must also wait for cooling
    logic gate_ff, nxt_gate;               // Registered gate enable
    logic sw_off_ff;                       // Software hold-off from CTRL
    logic start_ok, trip_now;

    // Start needs the whole window; software hold-off acts as a plain fault
    assign start_ok = uv_ok & ~ov_high & lock_ok & ~oc_now & ~sw_off_ff;  // R1
    assign trip_now = oc_fault | hot;

    // Next state of the sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_hold = hold_ff;
        nxt_thermal = thermal_ff;
        nxt_gate = 1'b0;
        case (state_ff)
            ST_OFF: begin
                if (start_ok & ~hot) begin
                    nxt_state = ST_ON;
                    nxt_gate = 1'b1;
                end
            end
            ST_ON: begin
                nxt_gate = 1'b1;
                if (trip_now) begin
                    nxt_gate = 1'b0;                   // R2 R9
                    nxt_thermal = hot;
                    nxt_hold = RESTART_HOLD_CYC;
                    nxt_state = AUTORETRY ? ST_HOLD : ST_LATCH;  // R12 R20
                end else if (~uv_ok | ov_high | ~lock_ok | sw_off_ff) begin
                    nxt_gate = 1'b0;                   // R2
                    nxt_state = ST_OFF;
                end
            end
            ST_HOLD: begin
                if (hold_ff != '0) begin
                    nxt_hold = hold_ff - 1'b1;         // R10 R13
                end else if (~thermal_ff | cooled) begin
                    nxt_thermal = 1'b0;                // R11 R18
                    nxt_state = ST_OFF;
                end
            end
            ST_LATCH: begin
                // Clearing by a low supply_above_min_in still honours the hold
                if (~uv_ok) begin
                    nxt_thermal = 1'b0;
                    nxt_hold = RESTART_HOLD_CYC;       // R13 R19
                    nxt_state = ST_HOLD;
                end
            end
            default: begin
                nxt_state = ST_OFF;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_OFF;
            hold_ff <= '0;
            thermal_ff <= 1'b0;
            gate_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            hold_ff <= nxt_hold;
            thermal_ff <= nxt_thermal;
            gate_ff <= nxt_gate;
        end
    end

    assign gate_enable_o = gate_ff;

    // ====================
    // Power-good
    logic pg_ff, nxt_pg;        // Asserted state, polarity free
    logic pg_out_ff, nxt_pg_out;  // Pin level after polarity

    // Only drain high, or undervoltage with the gate low, clears it, so overvoltage keeps it
    always_comb begin
        nxt_pg = pg_ff;
        if (~drain_low | (~gate_high & ~uv_ok)) begin
            nxt_pg = 1'b0;                             // R15 R17
        end else if (drain_low & gate_high) begin
            nxt_pg = 1'b1;                             // R14
        end
        nxt_pg_out = PG_ACTIVE_HIGH ? nxt_pg : ~nxt_pg;  // R16
    end

    // Power-good registers; the pin idles deasserted through reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pg_ff <= 1'b0;
            pg_out_ff <= ~PG_ACTIVE_HIGH;
        end else begin
            pg_ff <= nxt_pg;
            pg_out_ff <= nxt_pg_out;
        end
    end

    assign power_good_out_o = pg_out_ff;

    // ====================
    // Sticky fault causes
    logic [FAULT_W-1:0] fault_ff, nxt_fault, fault_set, fault_clr;
    logic leave_on;

    assign leave_on = (state_ff == ST_ON) & ~nxt_gate;
    assign fault_set = {5{leave_on}} & {~lock_ok, ov_high, ~uv_ok, hot, oc_fault};

    // A cause raised in the clearing cycle survives the clear
    always_comb begin
        nxt_fault = (fault_ff & ~fault_clr) | fault_set;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_ff <= FAULT_RESET;
        end else begin
            fault_ff <= nxt_fault;
        end
    end

    // ====================
    // AXI4-Lite write path
    logic aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
    logic [ADDR_W-1:0] waddr_ff, nxt_waddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic nxt_sw_off, do_write;

    // Address and data are taken in either order; one write at a time
    assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
    assign s_axi_wready = ~w_held_ff & ~bvalid_ff;
    assign do_write = aw_held_ff & w_held_ff;

    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_w_held = w_held_ff;
        nxt_waddr = waddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_sw_off = sw_off_ff;
        fault_clr = '0;
        if (s_axi_awvalid & s_axi_awready) begin
            nxt_aw_held = 1'b1;
            nxt_waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            nxt_w_held = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (do_write) begin
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            case (waddr_ff)
                CTRL_OFS: begin
                    if (wstrb_ff[0]) begin
                        nxt_sw_off = wdata_ff[0];
                    end
                end
                FAULT_OFS: begin
                    if (wstrb_ff[0]) begin
                        fault_clr = wdata_ff[FAULT_W-1:0];
                    end
                end
                STATUS_OFS, INTEG_OFS, CONFIG_OFS: begin
                    // Read-only words ignore writes
                end
                default: begin
                    nxt_bresp = RESP_SLVERR;
                end
            endcase
        end else if (bvalid_ff & s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            waddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            sw_off_ff <= CTRL_RESET;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            waddr_ff <= nxt_waddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            sw_off_ff <= nxt_sw_off;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // ====================
    // AXI4-Lite read path
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;

    assign s_axi_arready = ~rvalid_ff;

    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_arvalid & s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            nxt_rdata = '0;
            case (s_axi_araddr)
                CTRL_OFS: nxt_rdata = {31'h0, sw_off_ff};
                STATUS_OFS: nxt_rdata = {16'h0, sync_ff, 2'h0, state_ff, pg_ff, gate_ff,
                                         thermal_ff, oc_fault};
                FAULT_OFS: nxt_rdata = {27'h0, fault_ff};
                INTEG_OFS: nxt_rdata = {20'h0, integ_level};
                CONFIG_OFS: nxt_rdata = {29'h0, PG_ACTIVE_HIGH, LONG_LIMIT, AUTORETRY};
                default: nxt_rresp = RESP_SLVERR;
            endcase
        end else if (rvalid_ff & s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

endmodule : hot_swap_fault_sequencer

/* File: hot_swap_checker_properties.sv */
// Pin-level timing checks for the hot-swap fault sequencer
`timescale 1ns/1ps
module hot_swap_checker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic supply_above_min_in_i,
    input wire logic supply_high_flag_in_i,
    input wire logic lockout_release_level_i,
    input wire logic limit_trip_level_i,
    input wire logic load_side_low_threshold_i,
    input wire logic drive_margin_level_i,
    input wire logic overheat_limit_i,
    input wire logic gate_enable_o,
    input wire logic power_good_out_o,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    // ==========================================================
    // Overcurrent run counter
    // ==========================================================
    // Sixteen 640-cycle ticks, one partial tick and sync slack
    localparam logic [15:0] OC_MAX = 16'h2af8;
    logic [15:0] oc_run_ff; // Unbroken overcurrent cycles while driven
    logic [15:0] nxt_oc_run;
    // Restarts whenever the drive is off or the current is normal
    always_comb begin
        nxt_oc_run = (limit_trip_level_i && gate_enable_o) ? oc_run_ff + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oc_run_ff <= 16'h0000;
        end else begin
            oc_run_ff <= nxt_oc_run;
        end
    end
    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    start_window_a: assert property ($rose(gate_enable_o) |-> $past(supply_above_min_in_i, 3)
        && !$past(supply_high_flag_in_i, 3) && $past(lockout_release_level_i, 3)
        && !$past(limit_trip_level_i, 3)) else $error("gate rose outside start window");
    uv_gate_off_a: assert property ((!supply_above_min_in_i)[*4] |-> !gate_enable_o)
        else $error("gate kept on under undervoltage");
    ov_gate_off_a: assert property (supply_high_flag_in_i[*4] |-> !gate_enable_o)
        else $error("gate kept on under overvoltage");
    hot_gate_off_a: assert property (overheat_limit_i[*4] |-> !gate_enable_o)
        else $error("gate kept on while overheated");
    oc_trip_bound_a: assert property (oc_run_ff <= OC_MAX)
        else $error("overcurrent lasted past the limit");
    pg_drain_high_a: assert property ((!load_side_low_threshold_i)[*5] |-> power_good_out_o)
        else $error("power good asserted with drain high");
    pg_set_a: assert property ((load_side_low_threshold_i && drive_margin_level_i)[*6]
        |-> !power_good_out_o) else $error("power good missing");
    ov_keeps_pg_a: assert property ((!power_good_out_o && supply_above_min_in_i
        && load_side_low_threshold_i)[*5] |=> !power_good_out_o) else $error("power good toggled");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule : hot_swap_checker

bind hot_swap_fault_sequencer hot_swap_checker u_hot_swap_checker (.*);

/* File: power_module_model.sv */
// Downstream power module with an active-low enable input
`timescale 1ns/1ps
module power_module_model (
    input wire logic clk_i,
    input wire logic enable_n_i,
    output logic running_o
);
    // Module runs one clock after its enable is pulled low
    always_ff @(posedge clk_i) begin
        running_o <= !enable_n_i;
    end
endmodule : power_module_model

/* File: hot_swap_fault_sequencer_bench.sv */
// Self-checking bench for the hot-swap fault sequencer
`timescale 1ns/1ps
module hot_swap_fault_sequencer_bench;
    import hot_swap_pkg::*;
    logic clk_i, rst_n_i, uv, ov, lk, oc, dl, gh, ht, cl, awv, wv, bry, arv, rry;
    logic awr, wr, bv, arr, rv, gate, pg, run;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd, rdat;
    logic [1:0] br, rr, rrsp;
    int bad_count = 0;
    int samples_checked = 0;
    hot_swap_fault_sequencer #(.RESTART_HOLD_CYC(32'h000000c8)) u_hot_swap_fault_sequencer (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .supply_above_min_in_i(uv), .supply_high_flag_in_i(ov),
        .lockout_release_level_i(lk), .limit_trip_level_i(oc), .load_side_low_threshold_i(dl),
        .drive_margin_level_i(gh), .overheat_limit_i(ht), .overheat_cooled_i(cl),
        .gate_enable_o(gate), .power_good_out_o(pg), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .s_axi_rdata(rdat), .s_axi_rresp(rrsp));
    power_module_model u_power_module_model (.clk_i(clk_i), .enable_n_i(pg), .running_o(run));
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    task automatic axr(input logic [7:0] a);
        arv <= 1'b1;
        ara <= a;
        rry <= 1'b1;
        do @(posedge clk_i); while (!arr);
        arv <= 1'b0;
        do @(posedge clk_i); while (!rv);
        rd = rdat;
        rr = rrsp;
    endtask : axr
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awv <= 1'b1;
        wv <= 1'b1;
        awa <= a;
        wd <= d;
        bry <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end while (awv || wv);
        do @(posedge clk_i); while (!bv);
        rr = br;
    endtask : axw
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_start();
        chk(pg, 1'b1);
        axr(CONFIG_OFS);
        chk(rd, 32'h00000001);
        {uv, lk, oc} <= 3'h7;
        cyc(8);
        chk(gate, 1'b0);
        oc <= 1'b0;
        cyc(8);
        chk(gate, 1'b1);
        {dl, gh} <= 2'h3;
        cyc(8);
        chk({pg, run}, 2'h1);
    endtask : t_start
    // Drive drop after overvoltage must leave power good alone
    task automatic t_ov();
        {ov, gh} <= 2'h2;
        cyc(8);
        chk({gate, pg}, 2'h0);
        {ov, gh} <= 2'h1;
        cyc(8);
        chk(gate, 1'b1);
    endtask : t_ov
    task automatic t_oc();
        logic [31:0] r1;
        int n;
        oc <= 1'b1;
        cyc(1);
        oc <= 1'b0;
        cyc(700);
        axr(INTEG_OFS);
        r1 = rd;
        cyc(640);
        axr(INTEG_OFS);
        chk(r1 inside {32'h7f, 32'h80}, 1'b1);
        chk((r1 - rd) inside {32'h1, 32'h2}, 1'b1);
        oc <= 1'b1;
        n = 0;
        do begin cyc(1); n++; end while (gate === 1'b1);
        chk(n >= 9600 && n <= 11000, 1'b1);
        oc <= 1'b0;
        cyc(150);
        chk(gate, 1'b0);
        cyc(100);
        chk(gate, 1'b1);
    endtask : t_oc
    task automatic t_hot();
        ht <= 1'b1;
        cyc(8);
        chk(gate, 1'b0);
        ht <= 1'b0;
        cyc(400);
        chk(gate, 1'b0);
        cl <= 1'b1;
        cyc(8);
        chk(gate, 1'b1);
    endtask : t_hot
    task automatic t_reg_uv();
        axw(CTRL_OFS, 32'h00000001);
        cyc(6);
        chk({rr, gate}, {RESP_OKAY, 1'b0});
        axw(8'h40, 32'h00000001);
        chk(rr, RESP_SLVERR);
        axr(8'h40);
        chk(rr, RESP_SLVERR);
        axw(CTRL_OFS, 32'h00000000);
        cyc(8);
        chk(gate, 1'b1);
        {uv, gh} <= 2'h0;
        cyc(8);
        chk({gate, pg}, 2'h1);
    endtask : t_reg_uv
    task automatic summarize();
        if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    // ==========================================================
    // Clock, sequence and watchdog
    // ==========================================================
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        {rst_n_i, uv, ov, lk, oc, dl, gh, ht, cl, awv, wv, bry, arv, rry} = 14'h0000;
        {awa, ara, wd} = 48'h000000000000;
        cyc(16);
        rst_n_i <= 1'b1;
        cyc(4);
        t_start();
        t_ov();
        t_oc();
        t_hot();
        t_reg_uv();
        summarize();
    end
    initial begin
        cyc(30000);
        bad_count++;
        summarize();
    end
endmodule : hot_swap_fault_sequencer_bench
